//--- shared/lrdc_pkg.sv
// constants shared by the light result decode and configuration block
// Overview of operation
// - Exponent code 0 means 40.95 lux full scale at 0.01 lux per count, and each code up to 11 doubles both values, ending at 83865.60 lux and 20.48 lux per count.
// - A result word carries the exponent in bits 15:12 and the unsigned 12-bit count in bits 11:0.
// - With the exponent mask set and a manual range below 12 programmed, the reported exponent is zero.
// - A configuration write during a conversion abandons that conversion at once.
// - After such a write a fresh conversion starts if the new settings ask for one, otherwise the block stays idle.
// - The 16-bit configuration register sits at address 01h and resets to C810h.
// - Configuration bits 15:9 and 4:0 are writable, bits 8:5 are read-only and ignore writes.
// - Range code 12 selects the range automatically and the chosen range is reported as the exponent; codes 13 to 15 are reserved.
// - Mode 00 is shutdown, 01 a single conversion, 10 and 11 continuous conversions.
package lrdc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0]  ADDR_RESULT  = 8'h00;
  localparam logic [7:0]  ADDR_CONFIG  = 8'h01;
  localparam logic [15:0] CONFIG_RESET = 16'hc810;
  localparam logic [15:0] CONFIG_WMASK = 16'hfe1f;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // ****************************************************************
  // configuration fields
  // ****************************************************************
  localparam int RANGE_LSB = 12;
  localparam int ITIME_BIT = 11;
  localparam int MODE_LSB  = 9;
  localparam int OVR_BIT   = 8;
  localparam int DONE_BIT  = 7;
  localparam int EMASK_BIT = 2;

  localparam logic [3:0] RANGE_AUTO  = 4'hc;
  localparam logic [3:0] EXP_MAX     = 4'hb;
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;

  // ****************************************************************
  // data widths and scale
  // ****************************************************************
  localparam int MANT_W = 12;
  localparam int RAW_W  = 23;
  localparam logic [11:0] MANT_FULL = 12'hfff;
  // weights in hundredths of a lux: 0.01 at code 0, 40.95 full scale
  localparam int LSB0_CENTILUX = 1;
  localparam int FS0_CENTILUX  = 4095;
  localparam int TOP_CENTILUX  = 8386560;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ      = 25000000;
  localparam int SHORT_MS    = 100;
  localparam int LONG_MS     = 800;
  localparam int CYC_PER_MS  = CLK_HZ / 1000;
  localparam int SHORT_CYC   = SHORT_MS * CYC_PER_MS;
  localparam int LONG_CYC    = LONG_MS * CYC_PER_MS;
  localparam int CNT_W       = 25;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } lrdc_state_t;

  // smallest exponent whose range holds the raw value, capped at the top
  function automatic logic [3:0] lrdc_fit_exp(input logic [RAW_W-1:0] raw);
    logic [3:0] e;
    e = EXP_MAX;
    for (int i = 11; i >= 0; i--) begin
      if ((raw >> i) <= RAW_W'(FS0_CENTILUX)) begin
        e = 4'(i);
      end
    end
    return e;
  endfunction : lrdc_fit_exp

endpackage : lrdc_pkg

//--- core/lrdc_result_pack.sv
// packs a raw light value into the exponent and mantissa result word
module lrdc_result_pack (
  input  wire logic [22:0] raw,
  input  wire logic [3:0]  range_select,
  input  wire logic        exponent_mask_bit,
  output logic      [15:0] word,
  output logic             overrange_flag
);

  logic        auto_mode;
  logic [3:0]  exp_sel;
  logic [22:0] shifted;
  logic [11:0] mant;

  always_comb begin
    // reserved codes above the auto code also pick the range themselves
    auto_mode = (range_select >= lrdc_pkg::RANGE_AUTO);
    exp_sel = auto_mode ? lrdc_pkg::lrdc_fit_exp(raw)
            : ((range_select > lrdc_pkg::EXP_MAX) ? lrdc_pkg::EXP_MAX
                                                  : range_select);
    shifted = raw >> exp_sel;
    if (shifted > 23'(lrdc_pkg::MANT_FULL)) begin
      mant           = lrdc_pkg::MANT_FULL;
      overrange_flag = 1'b1;
    end else begin
      mant           = shifted[11:0];
      overrange_flag = 1'b0;
    end
    word = {(exponent_mask_bit && !auto_mode) ? 4'h0 : exp_sel, mant};
  end

endmodule : lrdc_result_pack

//--- core/lrdc_core.sv
// conversion sequencer and register file of the light result block
module lrdc_core #(
  parameter int SHORT_CYC = lrdc_pkg::SHORT_CYC,
  parameter int LONG_CYC  = lrdc_pkg::LONG_CYC
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata_q,
  input  wire logic [22:0] light_raw,
  output logic             converting_q,
  output logic             conv_done_q,
  output logic      [15:0] result_q
);

  localparam int W = lrdc_pkg::CNT_W;
  localparam int RL = lrdc_pkg::RANGE_LSB;
  localparam int ML = lrdc_pkg::MODE_LSB;

  // ****************************************************************
  // state
  // ****************************************************************
  lrdc_pkg::lrdc_state_t state_q, state_d;
  logic [15:0]  cfg_q, cfg_d;
  logic [15:0]  result_d;
  logic [15:0]  reg_rdata_d;
  logic [W-1:0] cnt_q, cnt_d;
  logic         conv_done_d;

  logic         wr_cfg;
  logic         rd_cfg;
  logic         cnt_end;
  logic         done_take;
  logic [15:0]  packed_word;
  logic         packed_ovr;
  logic [15:0]  cfg_wr_val;

  function automatic logic [W-1:0] conv_load(input logic long_time);
    return long_time ? W'(LONG_CYC - 1) : W'(SHORT_CYC - 1);
  endfunction : conv_load

  lrdc_result_pack u_pack (
    .raw               (light_raw),
    .range_select      (cfg_q[RL+3:RL]),
    .exponent_mask_bit (cfg_q[lrdc_pkg::EMASK_BIT]),
    .word              (packed_word),
    .overrange_flag    (packed_ovr)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    wr_cfg     = reg_wr && (reg_addr == lrdc_pkg::ADDR_CONFIG);
    rd_cfg     = reg_rd && (reg_addr == lrdc_pkg::ADDR_CONFIG);
    cnt_end    = (state_q == lrdc_pkg::ST_CONV) && (cnt_q == '0);
    done_take  = cnt_end && !wr_cfg;
    cfg_wr_val = (reg_wdata & lrdc_pkg::CONFIG_WMASK)
               | (cfg_q & ~lrdc_pkg::CONFIG_WMASK);
    state_d     = state_q;
    cfg_d       = cfg_q;
    cnt_d       = cnt_q;
    result_d    = result_q;
    conv_done_d = done_take;
    // flag clears when software reads it; a new result in the same cycle wins
    if (rd_cfg) begin
      cfg_d[lrdc_pkg::DONE_BIT] = 1'b0;
    end
    if (wr_cfg) begin
      cfg_d[15:9] = cfg_wr_val[15:9];
      cfg_d[4:0]  = cfg_wr_val[4:0];
      if (cfg_wr_val[ML+1:ML] != lrdc_pkg::MODE_OFF) begin
        state_d = lrdc_pkg::ST_CONV;
        cnt_d   = conv_load(cfg_wr_val[lrdc_pkg::ITIME_BIT]);
      end else begin
        state_d = lrdc_pkg::ST_IDLE;
        cnt_d   = '0;
      end
    end else if (done_take) begin
      result_d                 = packed_word;
      cfg_d[lrdc_pkg::OVR_BIT] = packed_ovr;
      cfg_d[lrdc_pkg::DONE_BIT] = 1'b1;
      if (cfg_q[ML+1:ML] == lrdc_pkg::MODE_SINGLE) begin
        cfg_d[ML+1:ML] = lrdc_pkg::MODE_OFF;
        state_d        = lrdc_pkg::ST_IDLE;
      end else begin
        cnt_d = conv_load(cfg_q[lrdc_pkg::ITIME_BIT]);
      end
    end else if (state_q == lrdc_pkg::ST_CONV) begin
      cnt_d = cnt_q - W'(1);
    end
    reg_rdata_d = reg_rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        lrdc_pkg::ADDR_RESULT: reg_rdata_d = result_q;
        lrdc_pkg::ADDR_CONFIG: reg_rdata_d = cfg_q;
        default:               reg_rdata_d = 16'h0000;
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_q      <= lrdc_pkg::ST_IDLE;
      cfg_q        <= lrdc_pkg::CONFIG_RESET;
      cnt_q        <= '0;
      result_q     <= lrdc_pkg::RESULT_RESET;
      reg_rdata_q  <= 16'h0000;
      conv_done_q  <= 1'b0;
      converting_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      cfg_q        <= cfg_d;
      cnt_q        <= cnt_d;
      result_q     <= result_d;
      reg_rdata_q  <= reg_rdata_d;
      conv_done_q  <= conv_done_d;
      converting_q <= (state_d == lrdc_pkg::ST_CONV);
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence cfg_write_s;
    reg_wr && (reg_addr == lrdc_pkg::ADDR_CONFIG);
  endsequence

  sequence busy_write_s;
    cfg_write_s ##0 (state_q == lrdc_pkg::ST_CONV);
  endsequence

  abort_on_write_a: assert property (busy_write_s |=> !conv_done_q)
    else $error("conversion completed despite config write");

  restart_conv_a: assert property (cfg_write_s ##0 (reg_wdata[10:9] != 2'h0)
    |=> (state_q == lrdc_pkg::ST_CONV) && converting_q
        && (cnt_q == conv_load($past(reg_wdata[11]))))
    else $error("no fresh conversion after config write");

  stay_idle_a: assert property (cfg_write_s ##0 (reg_wdata[10:9] == 2'h0)
    |=> ((state_q == lrdc_pkg::ST_IDLE) && !converting_q) [*2])
    else $error("conversion ran after shutdown write");

  cfg_reset_a: assert property (disable iff (1'b0)
    !nrst |=> (cfg_q == lrdc_pkg::CONFIG_RESET))
    else $error("config reset value wrong");

  ro_bits_a: assert property (cfg_write_s ##0 !rd_cfg
    |=> (cfg_q[8:5] == $past(cfg_q[8:5]))
        && (cfg_q[15:9] == $past(reg_wdata[15:9]))
        && (cfg_q[4:0] == $past(reg_wdata[4:0])))
    else $error("config write mask wrong");

  exp_cap_a: assert property (result_q[15:12] <= lrdc_pkg::EXP_MAX)
    else $error("result exponent above top range");

  mask_zero_a: assert property (conv_done_q && $past(cfg_q[2])
    && ($past(cfg_q[15:12]) < lrdc_pkg::RANGE_AUTO)
    |-> (result_q[15:12] == 4'h0))
    else $error("masked exponent not zero");

  manual_exp_a: assert property (conv_done_q && !$past(cfg_q[2])
    && ($past(cfg_q[15:12]) < lrdc_pkg::RANGE_AUTO)
    |-> (result_q[15:12] == $past(cfg_q[15:12])))
    else $error("manual exponent not reported");

  auto_fit_a: assert property (conv_done_q
    && ($past(cfg_q[15:12]) == lrdc_pkg::RANGE_AUTO)
    && (result_q[15:12] != 4'h0) |-> result_q[11])
    else $error("auto range not the smallest fitting");

  single_end_a: assert property (conv_done_q
    && ($past(cfg_q[10:9]) == lrdc_pkg::MODE_SINGLE)
    |-> (cfg_q[10:9] == lrdc_pkg::MODE_OFF) && !converting_q)
    else $error("single shot did not return to shutdown");

  done_flag_a: assert property (conv_done_q |-> cfg_q[7])
    else $error("done flag not set on new result");

  mant_weight_a: assert property (conv_done_q
    && ($past(cfg_q[RL+3:RL]) < lrdc_pkg::RANGE_AUTO)
    && !cfg_q[lrdc_pkg::OVR_BIT]
    |-> (result_q[11:0] == 12'($past(light_raw) >> $past(cfg_q[RL+3:RL]))))
    else $error("mantissa not scaled by range weight");

  ovr_flag_a: assert property (conv_done_q
    && ($past(cfg_q[RL+3:RL]) < lrdc_pkg::RANGE_AUTO)
    |-> (cfg_q[lrdc_pkg::OVR_BIT] == (($past(light_raw)
        >> $past(cfg_q[RL+3:RL])) > 23'(lrdc_pkg::MANT_FULL))))
    else $error("overrange flag wrong for range");

  done_clear_a: assert property (rd_cfg && !done_take
    |=> !cfg_q[lrdc_pkg::DONE_BIT])
    else $error("done flag not cleared by config read");

  cont_reload_a: assert property (conv_done_q && $past(cfg_q[ML+1])
    |-> converting_q && (cfg_q[ML+1:ML] == $past(cfg_q[ML+1:ML])))
    else $error("continuous conversion did not carry on");

  result_read_a: assert property (reg_rd
    && (reg_addr == lrdc_pkg::ADDR_RESULT)
    |=> (reg_rdata_q == $past(result_q)))
    else $error("result read data wrong");

  cfg_read_a: assert property (rd_cfg
    |=> (reg_rdata_q == $past(cfg_q)))
    else $error("config read data wrong");

  unmapped_zero_a: assert property (reg_rd
    && (reg_addr > lrdc_pkg::ADDR_CONFIG)
    |=> (reg_rdata_q == 16'h0000))
    else $error("unmapped read not zero");

endmodule : lrdc_core

//--- dv/lrdc_host_model.sv
// host model: register accesses and lux arithmetic
module lrdc_host_model (
  input  wire logic        clock,
  output logic      [7:0]  reg_addr,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata_q
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd    = 1'b0;
  end

  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clock);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clock);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata_q;
  endtask : rd

  function automatic int lux(input logic [15:0] w, input logic [3:0] e);
    return int'(w[11:0]) << e;
  endfunction : lux

endmodule : lrdc_host_model

//--- dv/test_light_result_decode_config.sv
// self-checking bench of the light result and configuration core
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("BAD %0t got %h exp %h", $time, got, exp); \
  end \
end

module test_light_result_decode_config;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [15:0] reg_wdata;
  logic        reg_rd;
  logic [15:0] reg_rdata_q;
  logic [22:0] light_raw = 23'h000000;
  logic        converting_q;
  logic        conv_done_q;
  logic [15:0] result_q;
  logic [15:0] d;
  int          err_count = 0;
  int          checks = 0;
  int          cycles = 0;
  int          n;
  int          want;

  always #20 clock = ~clock;

  lrdc_core #(.SHORT_CYC(8), .LONG_CYC(20)) uut (
    .clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .light_raw(light_raw), .converting_q(converting_q),
    .conv_done_q(conv_done_q), .result_q(result_q));

  lrdc_host_model host (
    .clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

  task automatic stop_test();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // bounded wait, n counts cycles from the write's edge to the done pulse
  task automatic wait_done(input int lim);
    n = 0;
    while (conv_done_q !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
  endtask : wait_done

  task automatic t_reset_map();
    host.rd(8'h01, d);
    `CHK(d, 16'hc810)
    host.rd(8'h05, d);
    `CHK(d, 16'h0000)
    host.wr(8'h01, 16'hf1ff);
    host.rd(8'h01, d);
    `CHK(d, 16'hf01f)
  endtask : t_reset_map

  task automatic t_masked_single();
    light_raw = 23'h0022b0;
    host.wr(8'h01, 16'h3204);
    wait_done(40);
    `CHK(n, 8)
    `CHK(result_q, 16'h0456)
    `CHK(host.lux(result_q, 4'h3), 8880)
    @(negedge clock);
    `CHK(converting_q, 1'b0)
    host.rd(8'h01, d);
    `CHK(d, 16'h3084)
    host.rd(8'h00, d);
    `CHK(d, 16'h0456)
  endtask : t_masked_single

  task automatic t_long_ovr();
    light_raw = 23'h001000;
    host.wr(8'h01, 16'h0a00);
    wait_done(40);
    `CHK(n, 20)
    `CHK(result_q, 16'h0fff)
    host.rd(8'h01, d);
    `CHK(d, 16'h0980)
    host.rd(8'h01, d);
    `CHK(d, 16'h0900)
    @(negedge clock);
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    nrst = 1'b1;
    `CHK(result_q, 16'h0000)
    host.rd(8'h01, d);
    `CHK(d, 16'hc810)
  endtask : t_long_ovr

  task automatic t_auto_ranges();
    for (int e = 0; e <= 12; e++) begin
      light_raw = (e == 12) ? 23'h7fffff : 23'(32'hfff << e);
      host.wr(8'h01, 16'hc200);
      wait_done(40);
      `CHK(n, 8)
      `CHK(result_q[15:12], (e == 12) ? 4'hb : 4'(e))
      `CHK(result_q[11:0], 12'hfff)
      want = 4095 << ((e == 12) ? 11 : e);
      `CHK(host.lux(result_q, result_q[15:12]), want)
    end
  endtask : t_auto_ranges

  task automatic t_abort();
    light_raw = 23'h000123;
    host.wr(8'h01, 16'h3600);
    repeat (3) @(negedge clock);
    host.wr(8'h01, 16'h3000);
    `CHK(converting_q, 1'b0)
    wait_done(20);
    `CHK(n, 20)
    host.wr(8'h01, 16'h3400);
    repeat (3) @(negedge clock);
    host.wr(8'h01, 16'h3200);
    wait_done(40);
    `CHK(n, 8)
    `CHK(result_q, 16'h3024)
    host.wr(8'h01, 16'h3600);
    wait_done(40);
    @(negedge clock);
    wait_done(40);
    `CHK(n + 1, 8)
    host.wr(8'h01, 16'h3000);
  endtask : t_abort

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      stop_test();
    end
  end

  initial begin
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    t_reset_map();
    t_masked_single();
    t_long_ovr();
    t_auto_ranges();
    t_abort();
    stop_test();
  end

endmodule : test_light_result_decode_config
